// >>> design/rcp_rail_ctrl.v
`timescale 1ns/1ps
`include "rcp_defs.vh"
// Summary of operation
// - control input rise enables group, fall disables
// - sleep input low sleeps group, high wakes
// - sleeping rail uses its own sleep voltage code
// - outputs one to three select open-drain or push-pull
// - general output shows group power-good or register bit
// - fourth general output is always open-drain
// - interrupt pin pulls low while interrupt pending, except while the programming level stands
// - fourth input at programming level enters programming
module rcp_rail_ctrl (
  input  wire        clk_i,
  input  wire        resetn_i,
  input  wire        ce_i,
  // register port
  input  wire [7:0]  reg_addr_i,
  input  wire [31:0] reg_wdata_i,
  input  wire        reg_wr_i,
  input  wire        reg_rd_i,
  output reg  [31:0] reg_rdata_o,
  // control pins
  input  wire        rail_ctrl_in_1_i,
  input  wire        rail_ctrl_in_2_i,
  input  wire        rail_ctrl_in_3_sleep_req_a_i,
  input  wire        rail_ctrl_in_4_prog_entry_i,
  input  wire        rail_ctrl_in_5_i,
  input  wire        rail_ctrl_in_6_sleep_req_b_i,
  input  wire        prog_level_det_i,
  // rail interface
  input  wire [7:0]  rail_pg_i,
  output reg  [7:0]  rail_en_o,
  output reg  [7:0]  rail_sleep_o,
  output reg  [63:0] rail_vcode_o,
  output reg         prog_mode_o,
  // general outputs
  output reg         gen_out_1_o,
  output reg         gen_out_1_oe_o,
  output reg         gen_out_2_o,
  output reg         gen_out_2_oe_o,
  output reg         gen_out_3_o,
  output reg         gen_out_3_oe_o,
  output reg         gen_out_4_od_o,
  output reg         gen_out_4_od_oe_o,
  // interrupt
  output reg         irq_out_n_o,
  output reg         irq_out_n_oe_o,
  output reg         irq_o
);
  // ****************************************
  // declarations
  // ****************************************
  wire [5:0]  ctl_s;             // synchronised control inputs
  wire        prog_s;            // synchronised programming level detect
  wire [7:0]  pg_s;              // synchronised power-good
  reg  [5:0]  ctl_prev_ff;       // last value for edge detection
  reg  [7:0]  pg_prev_ff;        // last power-good for loss events
  reg         slp_prev_a_ff;     // last sleep state of group a
  reg         slp_prev_b_ff;     // last sleep state of group b
  reg  [7:0]  grp_ff [0:5];      // rails assigned to each control input
  reg  [1:0]  slp_cfg_ff;        // sleep mode for inputs three and six
  reg  [7:0]  slp_grp_a_ff;      // rails put to sleep by input three
  reg  [7:0]  slp_grp_b_ff;      // rails put to sleep by input six
  reg  [11:0] gpo_cfg_ff;        // source, drive and software bits
  reg  [7:0]  gpo_pg_ff [0:3];   // power-good masks for each output
  reg  [3:0]  irq_stat_ff;       // sticky event bits
  reg  [3:0]  irq_mask_ff;       // 1 lets an event reach the pin
  reg  [7:0]  vnorm_ff [0:7];    // normal voltage codes
  reg  [7:0]  vslp_ff [0:7];     // sleep voltage codes
  reg  [7:0]  nxt_rail_en;
  reg  [7:0]  nxt_rail_sleep;
  reg  [63:0] nxt_vcode;
  reg  [3:0]  nxt_gpo_val;
  reg  [3:0]  irq_evt;
  reg  [31:0] nxt_rdata;
  reg  [5:0]  ctl_act;           // inputs acting as enables
  reg         sleep_a;
  reg         sleep_b;
  reg  [7:0]  on_mask;
  reg  [7:0]  off_mask;
  wire        wr_stat;
  integer     i;                 // loop index of the enable logic only
  integer     g;                 // loop index of the general outputs only
  integer     c;                 // loop index of the configuration registers only
  integer     r;                 // loop index of the read path only
  // one shared index would retrigger every always @* that reads it, a zero-time loop

  // ****************************************
  // pin synchronisation
  // ****************************************
  // all pins are asynchronous; a group must never see half an edge
  rcp_sync2 #(.W(15)) u_sync (
    .clk_i    (clk_i),
    .resetn_i (resetn_i),
    .ce_i     (ce_i),
    .d_i      ({rail_pg_i, prog_level_det_i,
                rail_ctrl_in_6_sleep_req_b_i, rail_ctrl_in_5_i,
                rail_ctrl_in_4_prog_entry_i, rail_ctrl_in_3_sleep_req_a_i,
                rail_ctrl_in_2_i, rail_ctrl_in_1_i}),
    .q_o      ({pg_s, prog_s, ctl_s})
  );

  // ****************************************
  // rail enable and sleep logic
  // ****************************************
  always @* begin
    ctl_act = 6'h3F;
    // inputs in sleep mode stop acting as enables
    if (slp_cfg_ff[`RCP_SLP_A_BIT]) ctl_act[2] = 1'b0;
    if (slp_cfg_ff[`RCP_SLP_B_BIT]) ctl_act[5] = 1'b0;
    // the programming level would read as a rise; keep rails quiet
    if (prog_s || prog_mode_o) ctl_act[3] = 1'b0;
    on_mask  = 8'h00;
    off_mask = 8'h00;
    for (i = 0; i < 6; i = i + 1) begin
      if (ctl_act[i] && ctl_s[i] && !ctl_prev_ff[i]) begin
        on_mask = on_mask | grp_ff[i];
      end
      if (ctl_act[i] && !ctl_s[i] && ctl_prev_ff[i]) begin
        off_mask = off_mask | grp_ff[i];
      end
    end
    // turn-on wins when two inputs disagree in one cycle
    nxt_rail_en = (rail_en_o & ~off_mask) | on_mask;
    // sleep request is active low
    sleep_a = slp_cfg_ff[`RCP_SLP_A_BIT] & ~ctl_s[2];
    sleep_b = slp_cfg_ff[`RCP_SLP_B_BIT] & ~ctl_s[5];
    nxt_rail_sleep = ({8{sleep_a}} & slp_grp_a_ff) | ({8{sleep_b}} & slp_grp_b_ff);
    for (i = 0; i < 8; i = i + 1) begin
      nxt_vcode[i*8 +: 8] = nxt_rail_sleep[i] ? vslp_ff[i] : vnorm_ff[i];
    end
  end

  // ****************************************
  // general output values
  // ****************************************
  always @* begin
    for (g = 0; g < 4; g = g + 1) begin
      if (gpo_cfg_ff[`RCP_GPO_SRC_LSB + g]) begin
        nxt_gpo_val[g] = gpo_cfg_ff[`RCP_GPO_SW_LSB + g];
      end else begin
        // unselected rails count as good; empty mask reads high
        nxt_gpo_val[g] = &(pg_s | ~gpo_pg_ff[g]);
      end
    end
  end

  // ****************************************
  // interrupt events
  // ****************************************
  always @* begin
    irq_evt = 4'h0;
    irq_evt[`RCP_IRQ_PROG_BIT]   = prog_s & ~prog_mode_o;
    irq_evt[`RCP_IRQ_PGLOST_BIT] = |(pg_prev_ff & ~pg_s & rail_en_o);
    irq_evt[`RCP_IRQ_SLEEP_BIT]  = (sleep_a ^ slp_prev_a_ff) | (sleep_b ^ slp_prev_b_ff);
    irq_evt[`RCP_IRQ_RAIL_BIT]   = |(nxt_rail_en ^ rail_en_o);
  end

  assign wr_stat = reg_wr_i && (reg_addr_i == `RCP_OFS_IRQ_STAT);

  // ****************************************
  // state and output registers
  // ****************************************
  always @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ctl_prev_ff       <= 6'h00;
      pg_prev_ff        <= 8'h00;
      slp_prev_a_ff     <= 1'b0;
      slp_prev_b_ff     <= 1'b0;
      rail_en_o         <= 8'h00;
      rail_sleep_o      <= 8'h00;
      rail_vcode_o      <= 64'h0000000000000000;
      prog_mode_o       <= 1'b0;
      irq_stat_ff       <= 4'h0;
      gen_out_1_o       <= 1'b0;
      gen_out_1_oe_o    <= 1'b0;
      gen_out_2_o       <= 1'b0;
      gen_out_2_oe_o    <= 1'b0;
      gen_out_3_o       <= 1'b0;
      gen_out_3_oe_o    <= 1'b0;
      gen_out_4_od_o    <= 1'b0;
      gen_out_4_od_oe_o <= 1'b0;
      irq_out_n_o       <= 1'b0;
      irq_out_n_oe_o    <= 1'b0;
      irq_o             <= 1'b0;
    end else if (ce_i) begin
      ctl_prev_ff   <= ctl_s;
      pg_prev_ff    <= pg_s;
      slp_prev_a_ff <= sleep_a;
      slp_prev_b_ff <= sleep_b;
      rail_en_o     <= nxt_rail_en;
      rail_sleep_o  <= nxt_rail_sleep;
      rail_vcode_o  <= nxt_vcode;
      prog_mode_o   <= prog_s;
      // write-one clears, but a new event in the same cycle survives
      if (wr_stat) begin
        irq_stat_ff <= (irq_stat_ff & ~reg_wdata_i[3:0]) | irq_evt;
      end else begin
        irq_stat_ff <= irq_stat_ff | irq_evt;
      end
      // push-pull drives the value; open-drain only pulls low
      gen_out_1_o    <= gpo_cfg_ff[`RCP_GPO_OD_LSB]     ? 1'b0 : nxt_gpo_val[0];
      gen_out_1_oe_o <= gpo_cfg_ff[`RCP_GPO_OD_LSB]     ? ~nxt_gpo_val[0] : 1'b1;
      gen_out_2_o    <= gpo_cfg_ff[`RCP_GPO_OD_LSB + 1] ? 1'b0 : nxt_gpo_val[1];
      gen_out_2_oe_o <= gpo_cfg_ff[`RCP_GPO_OD_LSB + 1] ? ~nxt_gpo_val[1] : 1'b1;
      gen_out_3_o    <= gpo_cfg_ff[`RCP_GPO_OD_LSB + 2] ? 1'b0 : nxt_gpo_val[2];
      gen_out_3_oe_o <= gpo_cfg_ff[`RCP_GPO_OD_LSB + 2] ? ~nxt_gpo_val[2] : 1'b1;
      gen_out_4_od_o    <= 1'b0;
      gen_out_4_od_oe_o <= ~nxt_gpo_val[3];
      // the pin never drives high, so the 7 V supply is not fought
      irq_out_n_o    <= 1'b0;
      irq_out_n_oe_o <= |(irq_stat_ff & irq_mask_ff) & ~prog_s;
      irq_o          <= |(irq_stat_ff & irq_mask_ff);
    end
  end

  // ****************************************
  // configuration registers
  // ****************************************
  always @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      for (c = 0; c < 6; c = c + 1) begin
        grp_ff[c] <= `RCP_RST_GRP;
      end
      for (c = 0; c < 4; c = c + 1) begin
        gpo_pg_ff[c] <= `RCP_RST_PG_MASK;
      end
      for (c = 0; c < 8; c = c + 1) begin
        vnorm_ff[c] <= `RCP_RST_VCODE;
        vslp_ff[c]  <= `RCP_RST_VCODE;
      end
      slp_cfg_ff   <= `RCP_RST_SLP_CFG;
      slp_grp_a_ff <= `RCP_RST_GRP;
      slp_grp_b_ff <= `RCP_RST_GRP;
      gpo_cfg_ff   <= `RCP_RST_GPO_CFG;
      irq_mask_ff  <= `RCP_RST_IRQ_MASK;
    end else if (ce_i && reg_wr_i) begin
      // word offsets built at eight bits so the compare stays address-wide
      for (c = 0; c < 6; c = c + 1) begin
        if (reg_addr_i == (`RCP_OFS_GRP0 + {c[5:0], 2'b00})) grp_ff[c] <= reg_wdata_i[7:0];
      end
      for (c = 0; c < 4; c = c + 1) begin
        if (reg_addr_i == (`RCP_OFS_GPO_PG0 + {c[5:0], 2'b00})) gpo_pg_ff[c] <= reg_wdata_i[7:0];
      end
      for (c = 0; c < 8; c = c + 1) begin
        if (reg_addr_i == (`RCP_OFS_VNORM0 + {c[5:0], 2'b00})) vnorm_ff[c] <= reg_wdata_i[7:0];
        if (reg_addr_i == (`RCP_OFS_VSLP0 + {c[5:0], 2'b00}))  vslp_ff[c]  <= reg_wdata_i[7:0];
      end
      case (reg_addr_i)
        `RCP_OFS_SLP_CFG:   slp_cfg_ff   <= reg_wdata_i[1:0];
        `RCP_OFS_SLP_GRP_A: slp_grp_a_ff <= reg_wdata_i[7:0];
        `RCP_OFS_SLP_GRP_B: slp_grp_b_ff <= reg_wdata_i[7:0];
        `RCP_OFS_GPO_CFG:   gpo_cfg_ff   <= reg_wdata_i[11:0];
        `RCP_OFS_IRQ_MASK:  irq_mask_ff  <= reg_wdata_i[3:0];
        default: ;
      endcase
    end
  end

  // ****************************************
  // read path
  // ****************************************
  // unmapped addresses read zero; no side effect on read
  always @* begin
    nxt_rdata = 32'h00000000;
    for (r = 0; r < 6; r = r + 1) begin
      if (reg_addr_i == (`RCP_OFS_GRP0 + {r[5:0], 2'b00})) nxt_rdata[7:0] = grp_ff[r];
    end
    for (r = 0; r < 4; r = r + 1) begin
      if (reg_addr_i == (`RCP_OFS_GPO_PG0 + {r[5:0], 2'b00})) nxt_rdata[7:0] = gpo_pg_ff[r];
    end
    for (r = 0; r < 8; r = r + 1) begin
      if (reg_addr_i == (`RCP_OFS_VNORM0 + {r[5:0], 2'b00})) nxt_rdata[7:0] = vnorm_ff[r];
      if (reg_addr_i == (`RCP_OFS_VSLP0 + {r[5:0], 2'b00}))  nxt_rdata[7:0] = vslp_ff[r];
    end
    case (reg_addr_i)
      `RCP_OFS_SLP_CFG:   nxt_rdata[1:0]  = slp_cfg_ff;
      `RCP_OFS_SLP_GRP_A: nxt_rdata[7:0]  = slp_grp_a_ff;
      `RCP_OFS_SLP_GRP_B: nxt_rdata[7:0]  = slp_grp_b_ff;
      `RCP_OFS_GPO_CFG:   nxt_rdata[11:0] = gpo_cfg_ff;
      `RCP_OFS_IRQ_STAT:  nxt_rdata[3:0]  = irq_stat_ff;
      `RCP_OFS_IRQ_MASK:  nxt_rdata[3:0]  = irq_mask_ff;
      `RCP_OFS_STATUS: begin
        nxt_rdata[`RCP_ST_EN_LSB +: 8]  = rail_en_o;
        nxt_rdata[`RCP_ST_SLP_LSB +: 8] = rail_sleep_o;
        nxt_rdata[`RCP_ST_PG_LSB +: 8]  = pg_s;
        nxt_rdata[`RCP_ST_PROG_BIT]     = prog_mode_o;
      end
      default: ;
    endcase
  end

  // read data stands only in the cycle after the strobe
  always @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      reg_rdata_o <= 32'h00000000;
    end else if (ce_i) begin
      reg_rdata_o <= reg_rd_i ? nxt_rdata : 32'h00000000;
    end
  end
endmodule // rcp_rail_ctrl

// >>> design/rcp_defs.vh
`ifndef RCP_DEFS_VH
`define RCP_DEFS_VH
// ****************************************
// register byte offsets
// ****************************************
`define RCP_OFS_GRP0       8'h00
`define RCP_OFS_SLP_CFG    8'h18
`define RCP_OFS_SLP_GRP_A  8'h1C
`define RCP_OFS_SLP_GRP_B  8'h20
`define RCP_OFS_GPO_CFG    8'h24
`define RCP_OFS_GPO_PG0    8'h28
`define RCP_OFS_IRQ_STAT   8'h38
`define RCP_OFS_IRQ_MASK   8'h3C
`define RCP_OFS_STATUS     8'h40
`define RCP_OFS_VNORM0     8'h80
`define RCP_OFS_VSLP0      8'hA0
// ****************************************
// field positions
// ****************************************
`define RCP_SLP_A_BIT      0
`define RCP_SLP_B_BIT      1
`define RCP_GPO_SRC_LSB    0
`define RCP_GPO_OD_LSB     4
`define RCP_GPO_SW_LSB     8
`define RCP_IRQ_PROG_BIT   0
`define RCP_IRQ_PGLOST_BIT 1
`define RCP_IRQ_SLEEP_BIT  2
`define RCP_IRQ_RAIL_BIT   3
`define RCP_ST_EN_LSB      0
`define RCP_ST_SLP_LSB     8
`define RCP_ST_PG_LSB      16
`define RCP_ST_PROG_BIT    24
// ****************************************
// reset values
// ****************************************
`define RCP_RST_GRP        8'h00
`define RCP_RST_SLP_CFG    2'h0
`define RCP_RST_GPO_CFG    12'h000
`define RCP_RST_PG_MASK    8'h00
`define RCP_RST_IRQ_MASK   4'h0
`define RCP_RST_VCODE      8'h00
`endif

// >>> design/rcp_sync2.v
`timescale 1ns/1ps
// two-stage synchroniser for a bundle of independent levels
module rcp_sync2 #(
  parameter W = 1
) (
  input  wire         clk_i,
  input  wire         resetn_i,
  input  wire         ce_i,
  input  wire [W-1:0] d_i,
  output wire [W-1:0] q_o
);
  reg [W-1:0] meta_ff;  // first stage, read only by second stage
  reg [W-1:0] sync_ff;  // second stage, safe to use

  // ****************************************
  // capture
  // ****************************************
  always @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      meta_ff <= {W{1'b0}};
      sync_ff <= {W{1'b0}};
    end else if (ce_i) begin
      meta_ff <= d_i;
      sync_ff <= meta_ff;
    end
  end

  assign q_o = sync_ff;
endmodule // rcp_sync2

// >>> dv/rcp_chk.sv
`timescale 1ns/1ps
// ****************************************
// pin-level checker of the rail control block
// ****************************************
module rcp_chk (
  input wire        clk_i,
  input wire        resetn_i,
  input wire        ce_i,
  input wire        reg_rd_i,
  input wire [31:0] reg_rdata_o,
  input wire        prog_level_det_i,
  input wire        prog_mode_o,
  input wire        gen_out_1_o,
  input wire        gen_out_1_oe_o,
  input wire        gen_out_2_o,
  input wire        gen_out_2_oe_o,
  input wire        gen_out_3_o,
  input wire        gen_out_3_oe_o,
  input wire        gen_out_4_od_o,
  input wire        irq_out_n_o,
  input wire        irq_out_n_oe_o,
  input wire        irq_o
);
  // one domain, so clock and reset are given once
  default clocking @(posedge clk_i); endclocking
  default disable iff (!resetn_i);
  // read data must not linger past its single cycle
  a_rdata_idle: assert property ($past(ce_i) && !$past(reg_rd_i) |-> reg_rdata_o == 32'h0)
    else $error("read data seen without a read");
  a_out4_od_low: assert property (gen_out_4_od_o == 1'b0)
    else $error("output four drives high");
  a_irq_od_low: assert property (irq_out_n_o == 1'b0)
    else $error("interrupt pin drives high");
  a_irq_pull_pend: assert property (irq_out_n_oe_o |-> irq_o)
    else $error("interrupt pin pulled with nothing pending");
  a_prog_irq_rel: assert property (prog_mode_o |-> !irq_out_n_oe_o)
    else $error("interrupt pin pulled during programming");
  // programming entry only after the level passed both sync stages
  a_prog_entry_sync: assert property ($rose(prog_mode_o) |-> $past(prog_level_det_i, 2))
    else $error("programming entered without a synced level");
  // a push-pull or open-drain pin never shows high undriven
  a_out1_drive_hi: assert property (gen_out_1_o |-> gen_out_1_oe_o)
    else $error("output one high while released");
  a_out2_drive_hi: assert property (gen_out_2_o |-> gen_out_2_oe_o)
    else $error("output two high while released");
  a_out3_drive_hi: assert property (gen_out_3_o |-> gen_out_3_oe_o)
    else $error("output three high while released");
endmodule // rcp_chk

bind rcp_rail_ctrl rcp_chk chk_u (
  .clk_i(clk_i), .resetn_i(resetn_i), .ce_i(ce_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
  .prog_level_det_i(prog_level_det_i), .prog_mode_o(prog_mode_o),
  .gen_out_1_o(gen_out_1_o), .gen_out_1_oe_o(gen_out_1_oe_o), .gen_out_2_o(gen_out_2_o),
  .gen_out_2_oe_o(gen_out_2_oe_o), .gen_out_3_o(gen_out_3_o), .gen_out_3_oe_o(gen_out_3_oe_o),
  .gen_out_4_od_o(gen_out_4_od_o), .irq_out_n_o(irq_out_n_o), .irq_out_n_oe_o(irq_out_n_oe_o), .irq_o(irq_o)
);

// >>> dv/rcp_host.sv
`timescale 1ns/1ps
// ****************************************
// host model driving the control pins
// ****************************************
module rcp_host (
  input  wire        clk_i,
  output logic [6:0] pin_o
);
  // bits 5:0 control inputs, bit 6 the programming level on input four
  initial pin_o = 7'h00;
  // pins move just after an edge and then hold for at least three edges
  // input four is raised only once the programming level stands
  task automatic set_pin(input int i, input bit v);
    @(posedge clk_i);
    pin_o[i] <= v;
  endtask
endmodule // rcp_host

// >>> dv/tb.sv
`timescale 1ns/1ps
`include "rcp_defs.vh"
module tb;
  // ****************************************
  // stimulus and observed signals
  // ****************************************
  logic        clk_i = 1'b0;
  logic        resetn_i = 1'b0;
  logic [7:0]  reg_addr_i = 8'h00;
  logic [31:0] reg_wdata_i = 32'h0;
  logic        reg_wr_i = 1'b0;
  logic        reg_rd_i = 1'b0;
  logic        ce_i = 1'b1;      // clock enable, dropped once to test the freeze
  logic [7:0]  rail_pg_i = 8'h00;
  wire  [31:0] reg_rdata_o;
  wire  [7:0]  rail_en_o, rail_sleep_o;
  wire  [63:0] rail_vcode_o;
  wire         prog_mode_o, irq_out_n_o, irq_out_n_oe_o, irq_o;
  wire  [3:0]  go, goe;          // general outputs, one to four
  wire  [6:0]  pin;              // host pins
  int          n_errors = 0;
  int          checks = 0;
  int          en, i;            // model of the rail enables
  int          grp[6];           // model of the group masks
  int          sel[$] = '{0, 1, 4};
  logic [7:0]  m;
  logic [31:0] rd;
  always #4 clk_i = ~clk_i;
  rcp_host host_u (.clk_i(clk_i), .pin_o(pin));
  rcp_rail_ctrl dut_u (
    .clk_i(clk_i), .resetn_i(resetn_i), .ce_i(ce_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
    .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .rail_ctrl_in_1_i(pin[0]),
    .rail_ctrl_in_2_i(pin[1]), .rail_ctrl_in_3_sleep_req_a_i(pin[2]), .rail_ctrl_in_4_prog_entry_i(pin[3]),
    .rail_ctrl_in_5_i(pin[4]), .rail_ctrl_in_6_sleep_req_b_i(pin[5]), .prog_level_det_i(pin[6]),
    .rail_pg_i(rail_pg_i), .rail_en_o(rail_en_o), .rail_sleep_o(rail_sleep_o), .rail_vcode_o(rail_vcode_o),
    .prog_mode_o(prog_mode_o), .gen_out_1_o(go[0]), .gen_out_1_oe_o(goe[0]), .gen_out_2_o(go[1]),
    .gen_out_2_oe_o(goe[1]), .gen_out_3_o(go[2]), .gen_out_3_oe_o(goe[2]), .gen_out_4_od_o(go[3]),
    .gen_out_4_od_oe_o(goe[3]), .irq_out_n_o(irq_out_n_o), .irq_out_n_oe_o(irq_out_n_oe_o), .irq_o(irq_o)
  );
  // ****************************************
  // shared tasks
  // ****************************************
  task automatic chk(input string nm, input logic [63:0] s, input logic [63:0] e);
    checks++;
    if (s !== e) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    reg_wr_i <= 1'b1; reg_addr_i <= a; reg_wdata_i <= d;
    @(posedge clk_i);
    reg_wr_i <= 1'b0;
  endtask
  // data stand only in the cycle after the strobe
  task automatic rdr(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk_i);
    reg_rd_i <= 1'b1; reg_addr_i <= a;
    @(posedge clk_i);
    reg_rd_i <= 1'b0;
    #1 d = reg_rdata_o;
  endtask
  // pin change must not act before the sync stages, then acts on the third edge
  task automatic step(input int p, input bit v, input logic [7:0] e, input logic [7:0] s);
    logic [7:0] e0, s0;
    e0 = rail_en_o;
    s0 = rail_sleep_o;
    host_u.set_pin(p, v);
    repeat (2) @(posedge clk_i);
    #1 chk("en_hold", rail_en_o, e0);
    chk("sleep_hold", rail_sleep_o, s0);
    @(posedge clk_i);
    #1 chk("rail_en", rail_en_o, e);
    chk("rail_sleep", rail_sleep_o, s);
  endtask
  task automatic summarize;
    $display("errors %0d checks %0d", n_errors, checks);
    if (n_errors == 0 && checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // hang guard, far above the roughly 130 cycles of the run
  initial begin
    #100000;
    n_errors++;
    summarize;
  end
  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    void'($urandom(70667));
    repeat (5) @(posedge clk_i);
    resetn_i <= 1'b1;
    rdr(`RCP_OFS_STATUS, rd); chk("status_rst", rd, 32'h0);
    rdr(`RCP_OFS_GPO_CFG, rd); chk("gpo_cfg_rst", rd, 32'h0);
    rdr(8'hF0, rd); chk("unmapped", rd, 32'h0);
    wr(`RCP_OFS_IRQ_MASK, 32'h8);
    // three plain inputs, each adding its group's rails to the enables
    en = 0;
    foreach (sel[k]) begin
      i = sel[k];
      grp[i] = ($urandom & 8'hFF) | (1 << k);
      wr(i * 4, grp[i]);
      step(i, 1'b1, en | grp[i], 8'h00);
      en = en | grp[i];
    end
    // software sees the same enables through the status word
    rdr(`RCP_OFS_STATUS, rd);
    chk("status_en", rd[7:0], en[7:0]);
    @(posedge clk_i);
    #1 chk("irq_set", irq_o, 1'b1);
    chk("irq_pin", irq_out_n_oe_o, 1'b1);
    wr(`RCP_OFS_IRQ_STAT, 32'h8);
    @(posedge clk_i);
    #1 chk("irq_clr", irq_o, 1'b0);
    foreach (sel[k]) begin
      en = en & ~grp[sel[k]];
      step(sel[k], 1'b0, en, 8'h00);
    end
    // both sleep inputs: low sleeps the group, rail takes its sleep code
    for (int j = 0; j < 2; j++) begin
      m = ($urandom & 8'hFF) | (1 << j);
      step(j * 3 + 2, 1'b1, 8'h00, 8'h00);
      wr(`RCP_OFS_SLP_GRP_A + 4 * j, m);
      wr(`RCP_OFS_VNORM0 + 4 * j, 32'h3C);
      wr(`RCP_OFS_VSLP0 + 4 * j, 32'hA5);
      wr(`RCP_OFS_SLP_CFG, 1 << j);
      step(j * 3 + 2, 1'b0, 8'h00, m);
      chk("vcode_sleep", rail_vcode_o[j*8+:8], 8'hA5);
      step(j * 3 + 2, 1'b1, 8'h00, 8'h00);
      chk("vcode_norm", rail_vcode_o[j*8+:8], 8'h3C);
    end
    // general outputs: soft bit, partial power-good, empty mask, drive kind
    wr(`RCP_OFS_GPO_PG0 + 4, 32'h3);
    rail_pg_i <= 8'h01;
    wr(`RCP_OFS_GPO_CFG, 32'h909);
    repeat (4) @(posedge clk_i);
    #1 chk("gpo_val_a", go, 4'b0101);
    chk("gpo_oe_a", goe, 4'b0111);
    rail_pg_i <= 8'h03;
    wr(`RCP_OFS_GPO_CFG, 32'h079);
    repeat (4) @(posedge clk_i);
    #1 chk("gpo_val_b", go, 4'b0000);
    chk("gpo_oe_b", goe, 4'b1001);
    // programming level: state entered, input four no enable, irq released
    wr(`RCP_OFS_GRP0 + 12, 32'hFF);
    // unmask programming entry so the pin is released with an event pending
    wr(`RCP_OFS_IRQ_MASK, 32'h9);
    host_u.set_pin(6, 1'b1);
    repeat (4) @(posedge clk_i);
    #1 chk("prog_mode", prog_mode_o, 1'b1);
    chk("irq_prog_pend", irq_o, 1'b1);
    chk("irq_release", irq_out_n_oe_o, 1'b0);
    step(3, 1'b1, 8'h00, 8'h00);
    // frozen clock enable: a pin change waits until the enable returns
    @(posedge clk_i);
    ce_i <= 1'b0;
    host_u.set_pin(0, 1'b1);
    repeat (4) @(posedge clk_i);
    #1 chk("ce_hold", rail_en_o, 8'h00);
    @(posedge clk_i);
    ce_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    #1 chk("ce_resume", rail_en_o, grp[0]);
    summarize;
  end
endmodule // tb
